//--- rtl/cfim_clock_fault_irq_mask_config.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// [R1] Fuse-locked stagger delay 4ms/40ms/400ms/4s
// [R2] Lock loss forces that loop output disabled
// [R3] Oscillator loss forces all loop outputs disabled
// [R4] Mask bits 7:4 block reference drift
// [R5] Mask bits 3:0 block reference clock loss
// [R6] Loop mask 7:4 blocks loss of lock
// [R7] Loop mask 3:0 blocks holdover freeze
// [R8] Address enable bit selects programmed address
// [R9] Address bits 6:2 hold upper address
// [R10] Interrupt on any unmasked fault event
// [R11] Host writes static bits before enabling
module cfim_clock_fault_irq_mask_config
  import cfim_pkg::*;
#(
  parameter int unsigned DLY0_CYC = DLY_SEL0_CYC,
  parameter int unsigned DLY1_CYC = DLY_SEL1_CYC,
  parameter int unsigned DLY2_CYC = DLY_SEL2_CYC,
  parameter int unsigned DLY3_CYC = DLY_SEL3_CYC
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic [7:0]   reg_addr_i,
  input  wire logic         reg_wr_i,
  input  wire logic         reg_rd_i,
  input  wire logic [7:0]   reg_wdata_i,
  output var  logic [7:0]   reg_rdata_o,
  input  wire logic         fuse_locked_i,
  input  wire logic         loops_start_i,
  output var  logic [3:0]   loop_enable_o,
  input  wire cfim_faults_t faults_i,
  input  wire logic         osc_loss_i,
  output var  logic [3:0]   pll_output_disable_o,
  output var  logic         fault_irq_o,
  output var  logic [6:0]   target_addr_o
);

  cfim_regs_t q;
  cfim_regs_t d;
  logic [DLY_CNT_W-1:0] dly_load;
  logic [15:0]          fault_vec;
  logic [15:0]          mask_vec;

  // ---------------------------------------------------------------
  // Delay selection and fault gathering
  // ---------------------------------------------------------------
  always_comb begin
    case (q.odc[ODC_DELAY_LSB +: 2]) // see [R1]
      2'h0:    dly_load = DLY_CNT_W'(DLY0_CYC - 1);
      2'h1:    dly_load = DLY_CNT_W'(DLY1_CYC - 1);
      2'h2:    dly_load = DLY_CNT_W'(DLY2_CYC - 1);
      default: dly_load = DLY_CNT_W'(DLY3_CYC - 1);
    endcase
  end

  // Loop mask bit 7 is loop a, so the loop vectors are bit-reversed.
  assign fault_vec = {faults_i.ref_drift, faults_i.ref_loss,
                      {<<{faults_i.loop_lol}},
                      {<<{faults_i.loop_holdover}}};
  assign mask_vec  = {q.src_mask, q.loop_mask}; // see [R4] see [R5]

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_OUTPUT_DISABLE_CTRL:         d.odc       = reg_wdata_i;
        OFS_CLOCK_SOURCE_FAULT_IRQ_MASK: d.src_mask  = reg_wdata_i;
        OFS_LOOP_FAULT_IRQ_MASK:         d.loop_mask = reg_wdata_i;
        OFS_PART_VARIANT_CONFIG:         d.variant   = reg_wdata_i;
        OFS_SERIAL_TARGET_ADDRESS: begin
          d.addr_en     = reg_wdata_i[STA_ENABLE_BIT];
          d.addr_static = reg_wdata_i[STA_STATIC_LSB +: 5];
        end
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_OUTPUT_DISABLE_CTRL:         d.rdata = q.odc;
        OFS_CLOCK_SOURCE_FAULT_IRQ_MASK: d.rdata = q.src_mask;
        OFS_LOOP_FAULT_IRQ_MASK:         d.rdata = q.loop_mask;
        OFS_PART_VARIANT_CONFIG:         d.rdata = q.variant;
        OFS_SERIAL_TARGET_ADDRESS:
          d.rdata = {q.addr_en, q.addr_static, 2'h0};
        default:                         d.rdata = 8'h00;
      endcase
    end

    // Loop a starts at once; with the fuse locked the rest follow after the delay, otherwise all four start together.
    case (q.st)
      CFIM_ST_IDLE: begin
        d.loop_en = 4'h0;
        if (loops_start_i) begin
          if (fuse_locked_i) begin
            d.st      = CFIM_ST_WAIT; // see [R1]
            d.cnt     = dly_load;
            d.loop_en = 4'h1;
          end else begin
            d.st      = CFIM_ST_ALL_ON;
            d.loop_en = 4'hF;
          end
        end
      end
      CFIM_ST_WAIT: begin
        if (!loops_start_i) begin
          d.st      = CFIM_ST_IDLE;
          d.loop_en = 4'h0;
        end else if (q.cnt == '0) begin
          d.st      = CFIM_ST_ALL_ON; // see [R1]
          d.loop_en = 4'hF;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      CFIM_ST_ALL_ON: begin
        if (!loops_start_i) begin
          d.st      = CFIM_ST_IDLE;
          d.loop_en = 4'h0;
        end
      end
      default: begin
        d.st      = CFIM_ST_IDLE;
        d.loop_en = 4'h0;
      end
    endcase

    d.out_dis = ({4{q.odc[ODC_LOCK_OEB_BIT]}} & faults_i.loop_lol) // see [R2]
              | {4{q.odc[ODC_OSC_OEB_BIT] & osc_loss_i}};         // see [R3]
    d.irq     = |(fault_vec & ~mask_vec); // see [R6] see [R7] see [R10]
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q             <= '0;
      q.odc         <= RST_OUTPUT_DISABLE_CTRL;
      q.src_mask    <= RST_IRQ_MASK;
      q.loop_mask   <= RST_IRQ_MASK;
      q.variant     <= RST_PART_VARIANT;
      q.addr_static <= RST_ADDR_STATIC;
      q.st          <= CFIM_ST_IDLE;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o          = q.rdata;
  assign loop_enable_o        = q.loop_en;
  assign pll_output_disable_o = q.out_dis;
  assign fault_irq_o          = q.irq;
  // The host relies on static bits being written before the enable.
  assign target_addr_o = q.addr_en // see [R8]
                       ? {q.addr_static, DEFAULT_TARGET_ADDR[1:0]} // see [R9]
                       : DEFAULT_TARGET_ADDR;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_stagger_a_first: assert property ( // see [R1]
    @(posedge ref_clk_i) disable iff (rst_i)
    (q.st == CFIM_ST_IDLE && loops_start_i && fuse_locked_i)
      |=> loop_enable_o == 4'h1 && q.cnt == $past(dly_load))
    else $error("loop a not started alone");
  a_stagger_release: assert property ( // see [R1]
    @(posedge ref_clk_i) disable iff (rst_i)
    (q.st == CFIM_ST_WAIT && loops_start_i && q.cnt == '0)
      |=> loop_enable_o == 4'hF)
    else $error("loops not released after delay");
  a_stagger_hold: assert property ( // see [R1]
    @(posedge ref_clk_i) disable iff (rst_i)
    (q.st == CFIM_ST_WAIT && loops_start_i && q.cnt != '0)
      |=> loop_enable_o == 4'h1)
    else $error("loops released early");
  a_lock_disable: assert property ( // see [R2]
    @(posedge ref_clk_i) disable iff (rst_i)
    (q.odc[ODC_LOCK_OEB_BIT] && faults_i.loop_lol[0])
      |=> pll_output_disable_o[0])
    else $error("lock loss did not disable output");
  a_osc_disable: assert property ( // see [R3]
    @(posedge ref_clk_i) disable iff (rst_i)
    (q.odc[ODC_OSC_OEB_BIT] && osc_loss_i) |=> pll_output_disable_o == 4'hF)
    else $error("oscillator loss did not disable outputs");
  a_drift_masked: assert property ( // see [R4]
    @(posedge ref_clk_i) disable iff (rst_i)
    (faults_i == cfim_faults_t'({4'h8, 12'h000}) && q.src_mask[7])
      |=> !fault_irq_o)
    else $error("masked drift raised interrupt");
  a_loss_unmasked: assert property ( // see [R5]
    @(posedge ref_clk_i) disable iff (rst_i)
    (faults_i.ref_loss[2] && !q.src_mask[2]) |=> fault_irq_o)
    else $error("unmasked clock loss lost");
  a_lol_masked: assert property ( // see [R6]
    @(posedge ref_clk_i) disable iff (rst_i)
    (faults_i == cfim_faults_t'({8'h00, 4'h1, 4'h0}) && q.loop_mask[7])
      |=> !fault_irq_o)
    else $error("masked loop a lock loss raised interrupt");
  a_holdover_irq: assert property ( // see [R7]
    @(posedge ref_clk_i) disable iff (rst_i)
    (faults_i.loop_holdover[3] && !q.loop_mask[0]) |=> fault_irq_o)
    else $error("loop d holdover not reported");
  a_addr_default: assert property ( // see [R8]
    @(posedge ref_clk_i) disable iff (rst_i)
    !q.addr_en |-> target_addr_o == 7'h69)
    else $error("default address wrong");
  a_addr_static: assert property ( // see [R9]
    @(posedge ref_clk_i) disable iff (rst_i)
    (reg_wr_i && reg_addr_i == OFS_SERIAL_TARGET_ADDRESS && reg_wdata_i[7])
      |=> target_addr_o[6:2] == $past(reg_wdata_i[6:2]))
    else $error("programmed address not applied");
  a_irq_quiet: assert property ( // see [R10]
    @(posedge ref_clk_i) disable iff (rst_i)
    (faults_i == '0) |=> !fault_irq_o)
    else $error("interrupt without fault");

endmodule : cfim_clock_fault_irq_mask_config

`default_nettype wire

//--- rtl/cfim_pkg.sv
`default_nettype none

package cfim_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_OUTPUT_DISABLE_CTRL   = 8'h26;
  localparam logic [7:0] OFS_CLOCK_SOURCE_FAULT_IRQ_MASK = 8'h27;
  localparam logic [7:0] OFS_LOOP_FAULT_IRQ_MASK   = 8'h28;
  localparam logic [7:0] OFS_PART_VARIANT_CONFIG   = 8'h29;
  localparam logic [7:0] OFS_SERIAL_TARGET_ADDRESS = 8'h2A;

  // Output disable control fields.
  localparam int         ODC_DELAY_LSB    = 2;
  localparam int         ODC_LOCK_OEB_BIT = 1;
  localparam int         ODC_OSC_OEB_BIT  = 0;

  // Serial target address fields.
  localparam int         STA_ENABLE_BIT   = 7;
  localparam int         STA_STATIC_LSB   = 2;

  // Reset values.
  localparam logic [7:0] RST_OUTPUT_DISABLE_CTRL = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK            = 8'h00;
  localparam logic [4:0] RST_ADDR_STATIC         = 5'h1A;
  localparam logic [6:0] DEFAULT_TARGET_ADDR     = 7'h69;
  // Arbitrary neutral variant code.
  localparam logic [7:0] RST_PART_VARIANT        = 8'h05;

  // ---------------------------------------------------------------
  // Stagger delay timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ    = 100_000_000;
  localparam int unsigned DLY_SEL0_US    = 4_000;
  localparam int unsigned DLY_SEL1_US    = 40_000;
  localparam int unsigned DLY_SEL2_US    = 400_000;
  localparam int unsigned DLY_SEL3_US    = 4_000_000;
  localparam int unsigned CYC_PER_US     = CLK_FREQ_HZ / 1_000_000;
  localparam int unsigned DLY_SEL0_CYC   = DLY_SEL0_US * CYC_PER_US;
  localparam int unsigned DLY_SEL1_CYC   = DLY_SEL1_US * CYC_PER_US;
  localparam int unsigned DLY_SEL2_CYC   = DLY_SEL2_US * CYC_PER_US;
  localparam int unsigned DLY_SEL3_CYC   = DLY_SEL3_US * CYC_PER_US;
  localparam int          DLY_CNT_W      = 29;

  typedef enum logic [1:0] {
    CFIM_ST_IDLE,
    CFIM_ST_WAIT,
    CFIM_ST_ALL_ON
  } cfim_state_t;

  typedef struct packed {
    logic [3:0] ref_drift;
    logic [3:0] ref_loss;
    logic [3:0] loop_lol;
    logic [3:0] loop_holdover;
  } cfim_faults_t;

  typedef struct packed {
    logic [7:0]           odc;
    logic [7:0]           src_mask;
    logic [7:0]           loop_mask;
    logic [7:0]           variant;
    logic                 addr_en;
    logic [4:0]           addr_static;
    logic [7:0]           rdata;
    cfim_state_t          st;
    logic [DLY_CNT_W-1:0] cnt;
    logic [3:0]           loop_en;
    logic [3:0]           out_dis;
    logic                 irq;
  } cfim_regs_t;

endpackage : cfim_pkg

`default_nettype wire

//--- testbench/cfim_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module cfim_host_model
  import cfim_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output var  logic [7:0] addr_o,
  output var  logic       wr_o,
  output var  logic       rd_o,
  output var  logic [7:0] wdata_o
);
  initial begin
    addr_o  = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 8'h00;
  end

  // ----------------------------------------------------------
  // Byte accesses
  // ----------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    // Stale write data is scrambled so that nothing relies on it.
    wdata_o <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    #1;
    d = rdata_i;
  endtask

  // The static bits are written first, then the enable joins them.
  task automatic set_addr(input logic [4:0] s);
    wr(OFS_SERIAL_TARGET_ADDRESS, {1'b0, s, 2'b00});
    wr(OFS_SERIAL_TARGET_ADDRESS, {1'b1, s, 2'b00});
  endtask
endmodule  // cfim_host_model

`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  miscompares++; $display("mismatch %s exp %h got %h", n, e, g); end end

module testbench
  import cfim_pkg::*;
;
  localparam int unsigned D[4] = '{4, 8, 12, 16};
  localparam logic [7:0] RST_EXP[5] =
    '{8'h00, 8'h00, 8'h00, RST_PART_VARIANT, 8'h68};

  logic         clk, rst, wr, rd, fuse, start, osc, irq;
  logic [7:0]   addr, wdata, rdata;
  logic [3:0]   loop_en, dis;
  logic [6:0]   taddr;
  cfim_faults_t faults;
  int           miscompares, cmp_count, cycles;

  cfim_clock_fault_irq_mask_config #(
    .DLY0_CYC(D[0]), .DLY1_CYC(D[1]), .DLY2_CYC(D[2]), .DLY3_CYC(D[3])
  ) u_dut (
    .ref_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .fuse_locked_i(fuse), .loops_start_i(start), .loop_enable_o(loop_en),
    .faults_i(faults), .osc_loss_i(osc), .pll_output_disable_o(dis),
    .fault_irq_o(irq), .target_addr_o(taddr)
  );

  cfim_host_model u_host (
    .clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata)
  );

  // ----------------------------------------------------------
  // Expectations and closing
  // ----------------------------------------------------------
  function automatic logic [3:0] rev(input logic [3:0] x);
    return {x[0], x[1], x[2], x[3]};
  endfunction

  function automatic logic exp_irq(cfim_faults_t f, logic [7:0] s,
                                   logic [7:0] l);
    return (|(f.ref_drift & ~s[7:4])) | (|(f.ref_loss & ~s[3:0]))
         | (|(f.loop_lol & ~rev(l[7:4])))
         | (|(f.loop_holdover & ~rev(l[3:0])));
  endfunction

  function automatic logic [3:0] exp_dis(logic [1:0] m, logic [3:0] lol,
                                         logic o);
    return (m[1] ? lol : 4'h0) | ((m[0] && o) ? 4'hF : 4'h0);
  endfunction

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      test_done();
    end
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    logic [7:0]   rv, sm, lm, odc;
    logic [4:0]   s;
    logic [3:0]   first;
    cfim_faults_t f;
    int           k, n;
    rst = 1'b1;
    fuse = 1'b0;
    start = 1'b0;
    osc = 1'b0;
    faults = '0;
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    void'($urandom(32'h75DE92DA));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK("target addr", DEFAULT_TARGET_ADDR, taddr)
    for (k = 0; k < 5; k++) begin
      u_host.rd(OFS_OUTPUT_DISABLE_CTRL + 8'(k), rv);
      `CHK("reset value", RST_EXP[k], rv)
    end
    u_host.wr(8'h30, 8'($urandom));
    u_host.rd(8'h30, rv);
    `CHK("unmapped", 8'h00, rv)
    for (k = 0; k < 40; k++) begin
      sm = (k == 0) ? 8'hFF : 8'($urandom);
      lm = (k == 0) ? 8'hFF : 8'($urandom);
      odc = 8'($urandom) & 8'h03;
      u_host.wr(OFS_CLOCK_SOURCE_FAULT_IRQ_MASK, sm);
      u_host.wr(OFS_LOOP_FAULT_IRQ_MASK, lm);
      u_host.wr(OFS_OUTPUT_DISABLE_CTRL, odc);
      u_host.rd(OFS_LOOP_FAULT_IRQ_MASK, rv);
      `CHK("loop mask", lm, rv)
      f = (k < 2) ? '1 : cfim_faults_t'(16'h0001 << ($urandom % 16));
      @(posedge clk);
      faults <= f;
      osc <= 1'($urandom);
      @(posedge clk);
      #1;
      `CHK("irq", exp_irq(f, sm, lm), irq)
      `CHK("out disable", exp_dis(odc[1:0], f.loop_lol, osc), dis)
    end
    s = 5'($urandom);
    u_host.set_addr(s);
    #1;
    `CHK("target addr", {s, 2'b01}, taddr)
    u_host.rd(OFS_SERIAL_TARGET_ADDRESS, rv);
    `CHK("addr reg", {1'b1, s, 2'b00}, rv)
    for (k = 0; k < 5; k++) begin
      u_host.wr(OFS_OUTPUT_DISABLE_CTRL, 8'(k % 4) << 2);
      fuse <= (k < 4);
      start <= 1'b1;
      n = 0;
      first = 4'h0;
      do begin
        @(posedge clk);
        #1;
        n++;
        if (n == 1) first = loop_en;
      end while (loop_en !== 4'hF && n < 100);
      `CHK("first loop", (k < 4) ? 4'h1 : 4'hF, first)
      // Loop a leads the others by exactly the programmed count.
      `CHK("stagger", (k < 4) ? int'(D[k]) + 1 : 1, n)
      start <= 1'b0;
      @(posedge clk);
      #1;
      `CHK("loops off", 4'h0, loop_en)
    end
    // A reset in mid-run must bring the registers back to their defaults.
    u_host.wr(OFS_CLOCK_SOURCE_FAULT_IRQ_MASK, 8'hA5);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK("target addr", DEFAULT_TARGET_ADDR, taddr)
    u_host.rd(OFS_CLOCK_SOURCE_FAULT_IRQ_MASK, rv);
    `CHK("reset mask", 8'h00, rv)
    test_done();
  end
endmodule  // testbench

`default_nettype wire
